// File: apu_playback.sv
// Module: primary playback rate accumulator, sample registers, volume and interrupt
`timescale 1ns/100ps
`default_nettype none
module apu_playback (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	output logic dac_clk_en,
	output logic dac_strobe,
	output logic [23:0] dac_left,
	output logic [23:0] dac_right,
	output logic ext_clk_out,
	output logic left_serial_out,
	output logic right_serial_out
);
	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] rate_lo_ff;
	logic [3:0] rate_hi_ff;
	logic [15:0] left_lo_ff;
	logic [15:0] left_hi_ff;
	logic [15:0] right_lo_ff;
	logic [15:0] right_hi_ff;
	logic [15:0] volume_ff;
	logic [12:0] mode_ff;
	logic [0:0] irq_stat_ff;
	logic [0:0] irq_mask_ff;
	logic [15:0] rdata_ff;
	logic [19:0] acc_ff;
	logic [2:0] fine_cnt_ff;
	logic [23:0] cap_left_ff;
	logic [23:0] cap_right_ff;
	logic cap_valid_ff;
	logic [6:0] smp_div_ff;

	logic [19:0] rate_inc;
	logic running;
	logic fine_extra;
	logic [20:0] acc_sum;
	logic rollover;
	logic acc_carry;
	logic [2:0] fine_limit;
	logic [6:0] fine_mask;
	logic [2:0] nxt_fine_cnt;
	logic [15:0] rd_mux;
	logic [0:0] irq_clear;
	logic [23:0] nxt_left;
	logic [23:0] nxt_right;

	apu_ser_if ser_bus ();

	// ****************************************
	// Functions
	// ****************************************
	// 10^(n/40) in Q1.14; values above 11 fall back to unity
	function automatic logic [15:0] fine_factor(input logic [3:0] code);
		logic [15:0] f;
		case (code)
			4'h0: f = 16'h4000;
			4'h1: f = 16'h43cb;
			4'h2: f = 16'h47cf;
			4'h3: f = 16'h4c10;
			4'h4: f = 16'h5092;
			4'h5: f = 16'h5558;
			4'h6: f = 16'h5a67;
			4'h7: f = 16'h5fc2;
			4'h8: f = 16'h656f;
			4'h9: f = 16'h6b72;
			4'ha: f = 16'h71cf;
			4'hb: f = 16'h788e;
			default: f = apu_pkg::GAIN_UNITY;
		endcase
		return f;
	endfunction : fine_factor

	// Shift then gain; gain tops out near +5.5 dB, so full scale input may clip
	function automatic logic [23:0] apply_volume(input logic [23:0] smp, input logic [3:0] coarse,
			input logic [3:0] fine);
		logic signed [23:0] shifted;
		logic signed [40:0] prod;
		logic signed [40:0] scaled;
		shifted = $signed(smp) >>> coarse;
		prod = shifted * $signed({1'b0, fine_factor(fine)});
		scaled = prod >>> 14;
		if (scaled > 41'sh000007fffff) begin
			apply_volume = 24'h7fffff;
		end else if (scaled < -41'sh00000800000) begin
			apply_volume = 24'h800000;
		end else begin
			apply_volume = scaled[23:0];
		end
	endfunction : apply_volume

	function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ref_addr);
		return a == ref_addr;
	endfunction : addr_is

	// ****************************************
	// Rate accumulator
	// ****************************************
	assign rate_inc = {rate_hi_ff, rate_lo_ff};
	assign running = (rate_inc != 20'h00000);
	assign fine_limit = mode_ff[apu_pkg::MODE_LIMIT_MSB:apu_pkg::MODE_LIMIT_LSB];
	assign fine_mask = mode_ff[apu_pkg::MODE_MASK_MSB:apu_pkg::MODE_MASK_LSB];
	assign fine_extra = (fine_limit != 3'h0) && fine_mask[fine_cnt_ff];
	assign nxt_fine_cnt = (fine_cnt_ff >= fine_limit) ? 3'h0 : fine_cnt_ff + 3'h1;
	// Double rate adds the increment twice, so the carry comes twice as often
	assign acc_sum = mode_ff[apu_pkg::MODE_DOUBLE_BIT] ?
		{1'b0, acc_ff} + {1'b0, rate_inc} + {1'b0, rate_inc} + {20'h00000, fine_extra} :
		{1'b0, acc_ff} + {1'b0, rate_inc} + {20'h00000, fine_extra};
	assign acc_carry = running && acc_sum[20];
	// One input sample per 128 carries; the carry itself only advances the sample divider
	assign rollover = acc_carry && (smp_div_ff == apu_pkg::SMP_DIV_LAST);

	// System clock stands in for the crystal; no PLL path feeds this logic
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_ff <= 20'h00000;
			fine_cnt_ff <= 3'h0;
			smp_div_ff <= 7'h00;
		end else if (!running) begin
			acc_ff <= 20'h00000;
			fine_cnt_ff <= 3'h0;
			smp_div_ff <= 7'h00;
		end else begin
			acc_ff <= acc_sum[19:0];
			smp_div_ff <= acc_carry ? smp_div_ff + 7'h01 : smp_div_ff;
			fine_cnt_ff <= (fine_limit == 3'h0) ? 3'h0 : nxt_fine_cnt;
		end
	end

	// ****************************************
	// Sample capture and volume
	// ****************************************
	assign nxt_left = {left_hi_ff, left_lo_ff[15:8]};
	assign nxt_right = {right_hi_ff, right_lo_ff[15:8]};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_left_ff <= 24'h000000;
			cap_right_ff <= 24'h000000;
			cap_valid_ff <= 1'b0;
		end else begin
			cap_valid_ff <= rollover;
			if (rollover) begin
				cap_left_ff <= nxt_left;
				cap_right_ff <= nxt_right;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dac_left <= 24'h000000;
			dac_right <= 24'h000000;
			dac_strobe <= 1'b0;
			dac_clk_en <= 1'b0;
		end else begin
			dac_strobe <= cap_valid_ff;
			dac_clk_en <= running;
			if (cap_valid_ff) begin
				dac_left <= apply_volume(cap_left_ff, volume_ff[11:8], volume_ff[15:12]);
				dac_right <= apply_volume(cap_right_ff, volume_ff[3:0], volume_ff[7:4]);
			end
		end
	end

	assign ser_bus.load = dac_strobe;
	assign ser_bus.left = dac_left;
	assign ser_bus.right = dac_right;
	assign ser_bus.run = running;
	assign ser_bus.ext3m = mode_ff[apu_pkg::MODE_EXT3M_BIT];

	apu_serial u_serial (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.fr(ser_bus.ser),
		.ext_clk_out(ext_clk_out),
		.left_serial_out(left_serial_out),
		.right_serial_out(right_serial_out)
	);

	// ****************************************
	// Register bus
	// ****************************************
	assign irq_clear = (reg_wr && addr_is(reg_addr, apu_pkg::ADDR_IRQ_STAT)) ?
		reg_wdata[0:0] : 1'b0;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rate_lo_ff <= apu_pkg::REG_RESET;
			rate_hi_ff <= 4'h0;
			left_lo_ff <= apu_pkg::REG_RESET;
			left_hi_ff <= apu_pkg::REG_RESET;
			right_lo_ff <= apu_pkg::REG_RESET;
			right_hi_ff <= apu_pkg::REG_RESET;
			volume_ff <= apu_pkg::REG_RESET;
			mode_ff <= 13'h0000;
			irq_mask_ff <= 1'b0;
		end else if (reg_wr) begin
			if (addr_is(reg_addr, apu_pkg::ADDR_RATE_LO)) rate_lo_ff <= reg_wdata;
			if (addr_is(reg_addr, apu_pkg::ADDR_RATE_HI)) rate_hi_ff <= reg_wdata[3:0];
			if (addr_is(reg_addr, apu_pkg::ADDR_LEFT_LO)) left_lo_ff <= {reg_wdata[15:8], 8'h00};
			if (addr_is(reg_addr, apu_pkg::ADDR_LEFT_HI)) left_hi_ff <= reg_wdata;
			if (addr_is(reg_addr, apu_pkg::ADDR_RIGHT_LO)) right_lo_ff <= {reg_wdata[15:8], 8'h00};
			if (addr_is(reg_addr, apu_pkg::ADDR_RIGHT_HI)) right_hi_ff <= reg_wdata;
			if (addr_is(reg_addr, apu_pkg::ADDR_VOLUME)) volume_ff <= reg_wdata;
			// Mode keeps bits 12:0 as written except bit 3, which always reads zero; software idles the rate first
			if (addr_is(reg_addr, apu_pkg::ADDR_MODE)) begin
				mode_ff <= {reg_wdata[12:4], 1'b0, reg_wdata[2:0]};
			end
			if (addr_is(reg_addr, apu_pkg::ADDR_IRQ_MASK)) irq_mask_ff <= reg_wdata[0:0];
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_ff <= 1'b0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clear) | rollover;
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	always_comb begin
		rd_mux = 16'h0000;
		case (reg_addr)
			apu_pkg::ADDR_RATE_LO: rd_mux = rate_lo_ff;
			apu_pkg::ADDR_RATE_HI: rd_mux = {12'h000, rate_hi_ff};
			apu_pkg::ADDR_LEFT_LO: rd_mux = left_lo_ff;
			apu_pkg::ADDR_LEFT_HI: rd_mux = left_hi_ff;
			apu_pkg::ADDR_RIGHT_LO: rd_mux = right_lo_ff;
			apu_pkg::ADDR_RIGHT_HI: rd_mux = right_hi_ff;
			apu_pkg::ADDR_VOLUME: rd_mux = volume_ff;
			apu_pkg::ADDR_MODE: rd_mux = {3'h0, mode_ff};
			apu_pkg::ADDR_IRQ_STAT: rd_mux = {15'h0000, irq_stat_ff};
			apu_pkg::ADDR_IRQ_MASK: rd_mux = {15'h0000, irq_mask_ff};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	assign reg_rdata = rdata_ff;
endmodule : apu_playback
`default_nettype wire

// File: apu_pkg.sv
// Package: register map, field positions and constants of the playback upconverter
package apu_pkg;
	localparam logic [15:0] ADDR_RATE_LO = 16'hfc34;
	localparam logic [15:0] ADDR_RATE_HI = 16'hfc35;
	localparam logic [15:0] ADDR_LEFT_LO = 16'hfc36;
	localparam logic [15:0] ADDR_LEFT_HI = 16'hfc37;
	localparam logic [15:0] ADDR_RIGHT_LO = 16'hfc38;
	localparam logic [15:0] ADDR_RIGHT_HI = 16'hfc39;
	localparam logic [15:0] ADDR_VOLUME = 16'hfec0;
	localparam logic [15:0] ADDR_MODE = 16'hfed9;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hfeda;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hfedb;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int MODE_EXT3M_BIT = 12;
	localparam int MODE_DOUBLE_BIT = 11;
	localparam int MODE_MASK_LSB = 4;
	localparam int MODE_MASK_MSB = 10;
	localparam int MODE_LIMIT_LSB = 0;
	localparam int MODE_LIMIT_MSB = 2;
	localparam int VOL_LFINE_LSB = 12;
	localparam int VOL_LCOARSE_LSB = 8;
	localparam int VOL_RFINE_LSB = 4;
	localparam int VOL_RCOARSE_LSB = 0;
	localparam int IRQ_SAMPLE_BIT = 0;
	localparam int IRQ_WIDTH = 1;
	localparam int ACC_WIDTH = 20;
	// Accumulator carries per input sample: 2^27 rate divisor over a 2^20 accumulator
	localparam logic [6:0] SMP_DIV_LAST = 7'h7f;
	localparam int SAMPLE_WIDTH = 24;
	localparam int GAIN_WIDTH = 16;
	localparam logic [3:0] FINE_MAX = 4'hb;
	// Unity gain in Q1.14 and the eleven 0.5 dB step factors
	localparam logic [15:0] GAIN_UNITY = 16'h4000;
	localparam int SYS_CLK_MHZ = 100;
	localparam int EXT_CLK_6M_MHZ = 6;
	localparam int EXT_CLK_3M_MHZ = 3;
	// Half periods of the derived clocks, rounded down
	localparam logic [4:0] HALF_6M = 5'(SYS_CLK_MHZ / (2 * EXT_CLK_6M_MHZ));
	localparam logic [4:0] HALF_3M = 5'(SYS_CLK_MHZ / (2 * EXT_CLK_3M_MHZ));
	localparam int SER_BITS = 32;
endpackage : apu_pkg

// File: apu_ser_if.sv
// Interface: frame hand-off from playback core to serial converter driver
`timescale 1ns/100ps
`default_nettype none
interface apu_ser_if;
	logic load;
	logic ext3m;
	logic run;
	logic [23:0] left;
	logic [23:0] right;
	modport core (output load, output ext3m, output run, output left, output right);
	modport ser (input load, input ext3m, input run, input left, input right);
endinterface : apu_ser_if
`default_nettype wire

// File: apu_serial.sv
// Module: external serial converter clock and data driver
`timescale 1ns/100ps
`default_nettype none
module apu_serial (
	input wire logic sys_clk,
	input wire logic arst_n,
	apu_ser_if.ser fr,
	output logic ext_clk_out,
	output logic left_serial_out,
	output logic right_serial_out
);
	logic [4:0] div_cnt_ff;
	logic clk6_ff;
	logic clk3_ff;
	logic [23:0] lsh_ff;
	logic [23:0] rsh_ff;
	logic [4:0] nxt_div_cnt;
	logic half_done;
	logic fall6;

	// Data bit period fixed by the 6 MHz clock; rounding makes it slightly fast
	localparam logic [4:0] HALF_LIM = apu_pkg::HALF_6M;
	assign half_done = (div_cnt_ff == HALF_LIM - 5'h01);
	assign nxt_div_cnt = half_done ? 5'h00 : div_cnt_ff + 5'h01;
	assign fall6 = half_done && clk6_ff;
	assign ext_clk_out = fr.ext3m ? clk3_ff : clk6_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_ff <= 5'h00;
			clk6_ff <= 1'b0;
			clk3_ff <= 1'b0;
		end else if (!fr.run) begin
			div_cnt_ff <= 5'h00;
			clk6_ff <= 1'b0;
			clk3_ff <= 1'b0;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			if (half_done) begin
				clk6_ff <= ~clk6_ff;
			end
			if (fall6) begin
				clk3_ff <= ~clk3_ff;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lsh_ff <= 24'h000000;
			rsh_ff <= 24'h000000;
			left_serial_out <= 1'b0;
			right_serial_out <= 1'b0;
		end else if (fr.load) begin
			lsh_ff <= fr.left;
			rsh_ff <= fr.right;
		end else if (fall6) begin
			left_serial_out <= lsh_ff[23];
			right_serial_out <= rsh_ff[23];
			lsh_ff <= {lsh_ff[22:0], 1'b0};
			rsh_ff <= {rsh_ff[22:0], 1'b0};
		end
	end
endmodule : apu_serial
`default_nettype wire

// File: apu_playback_asserts.sv
// Checker: port-level properties of the playback block
`timescale 1ns/100ps
`default_nettype none
module apu_playback_asserts (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic irq,
	input wire logic dac_clk_en,
	input wire logic dac_strobe,
	input wire logic ext_clk_out
);
	// ****************
	// Shadow of rate and clock mode
	// ****************
	logic [19:0] rate_ff;
	logic m3_ff;
	wire logic wr_lo = reg_wr && reg_addr == apu_pkg::ADDR_RATE_LO;
	wire logic wr_hi = reg_wr && reg_addr == apu_pkg::ADDR_RATE_HI;
	wire logic wr_md = reg_wr && reg_addr == apu_pkg::ADDR_MODE;
	wire logic wr_irq = reg_wr &&
		(reg_addr == apu_pkg::ADDR_IRQ_STAT || reg_addr == apu_pkg::ADDR_IRQ_MASK);
	wire logic rate_nz = |rate_ff;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rate_ff <= 20'h00000;
			m3_ff <= 1'b0;
		end else begin
			if (wr_lo) rate_ff[15:0] <= reg_wdata;
			if (wr_hi) rate_ff[19:16] <= reg_wdata[3:0];
			if (wr_md) m3_ff <= reg_wdata[apu_pkg::MODE_EXT3M_BIT];
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	property p_rd_quiet;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
	property p_en_on;
		$rose(rate_nz) |-> ##[0:2] dac_clk_en;
	endproperty
	a_en_on: assert property (p_en_on) else $error("converter clock not started");
	property p_en_off;
		$fell(rate_nz) |-> ##[0:2] !dac_clk_en;
	endproperty
	a_en_off: assert property (p_en_off) else $error("converter clock not stopped");
	property p_idle_strobe;
		!dac_clk_en [*4] |-> !dac_strobe;
	endproperty
	a_idle_strobe: assert property (p_idle_strobe) else $error("strobe while idle");
	property p_idle_clk;
		(!dac_clk_en && !rate_nz) [*8] |-> !ext_clk_out;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("external clock while idle");
	// Pulses cut short by a stop are excluded through the rate shadow
	property p_ext6;
		$fell(ext_clk_out) && dac_clk_en && rate_nz && !m3_ff |->
			$past(ext_clk_out, 8) && !$past(ext_clk_out, 9);
	endproperty
	a_ext6: assert property (p_ext6) else $error("fast clock high time wrong");
	property p_ext3;
		$fell(ext_clk_out) && dac_clk_en && rate_nz && m3_ff |->
			$past(ext_clk_out, 16) && !$past(ext_clk_out, 17);
	endproperty
	a_ext3: assert property (p_ext3) else $error("slow clock high time wrong");
	property p_irq_mask;
		wr_irq && reg_addr == apu_pkg::ADDR_IRQ_MASK && !reg_wdata[0] |=> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt high");
	property p_irq_hold;
		irq && !wr_irq |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
	property p_strobe_irq;
		$rose(irq) && !$past(reg_wr) |-> ##[1:3] dac_strobe;
	endproperty
	a_strobe_irq: assert property (p_strobe_irq) else $error("no strobe after request");
endmodule : apu_playback_asserts
bind apu_playback apu_playback_asserts u_asserts (.sys_clk(sys_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq(irq), .dac_clk_en(dac_clk_en), .dac_strobe(dac_strobe),
	.ext_clk_out(ext_clk_out));
`default_nettype wire

// File: apu_dac_model.sv
// Partner model: external converter taking strobed samples and serial frames
`timescale 1ns/100ps
`default_nettype none
module apu_dac_model (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic dac_strobe,
	input wire logic [23:0] dac_left,
	input wire logic [23:0] dac_right,
	input wire logic ext_clk_out,
	input wire logic left_serial_out,
	input wire logic right_serial_out,
	output logic got_left,
	output logic got_right
);
	// ****************
	// Receive side
	// ****************
	logic [23:0] sh_l, sh_r, want_l, want_r;
	logic clk_q;
	// Runs off the crystal-rate clock only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{sh_l, sh_r, want_l, want_r} <= '0;
			{clk_q, got_left, got_right} <= '0;
		end else begin
			clk_q <= ext_clk_out;
			// Taken on the rise, away from the falling-edge launch
			if (ext_clk_out && !clk_q) begin
				sh_l <= {sh_l[22:0], left_serial_out};
				sh_r <= {sh_r[22:0], right_serial_out};
			end
			// No frame sync, so a frame counts once its bits line up
			if (sh_l == want_l) got_left <= 1'b1;
			if (sh_r == want_r) got_right <= 1'b1;
			if (dac_strobe) begin
				want_l <= dac_left;
				want_r <= dac_right;
				got_left <= 1'b0;
				got_right <= 1'b0;
			end
		end
	end
endmodule : apu_dac_model
`default_nettype wire

// File: apu_playback_tb_top.sv
// Testbench: registers, rate, interrupt, volume and serial scenarios
`timescale 1ns/100ps
`default_nettype none
module apu_playback_tb_top;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic irq, dac_clk_en, dac_strobe, ext_clk_out, ser_l, ser_r, got_left, got_right;
	logic [23:0] dac_left, dac_right;
	int fails = 0;
	int compares = 0;
	always #5 sys_clk = ~sys_clk;
	apu_playback dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .dac_clk_en(dac_clk_en), .dac_strobe(dac_strobe), .dac_left(dac_left),
		.dac_right(dac_right), .ext_clk_out(ext_clk_out), .left_serial_out(ser_l),
		.right_serial_out(ser_r));
	apu_dac_model u_model (.sys_clk(sys_clk), .arst_n(arst_n), .dac_strobe(dac_strobe),
		.dac_left(dac_left), .dac_right(dac_right), .ext_clk_out(ext_clk_out),
		.left_serial_out(ser_l), .right_serial_out(ser_r), .got_left(got_left),
		.got_right(got_right));
	// ****************
	// Bus and compare tasks
	// ****************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 check("rdata", exp, reg_rdata);
	endtask : rd
	task automatic count(input int len, output int c);
		c = 0;
		repeat (32) @(posedge sys_clk);
		repeat (len) begin
			@(posedge sys_clk);
			#1 c += int'(dac_strobe === 1'b1);
		end
	endtask : count
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (irq !== 1'b1 && n < 1200);
		check("irq", 1, irq);
	endtask : wait_irq
	task automatic play(input logic [15:0] vol, input logic [23:0] l, input logic [23:0] r,
		input logic [23:0] el, input logic [23:0] er);
		int n;
		wr(apu_pkg::ADDR_VOLUME, vol);
		wr(apu_pkg::ADDR_IRQ_STAT, 16'h0001);
		wait_irq();
		wr(apu_pkg::ADDR_IRQ_STAT, 16'h0001);
		#1 check("irq clear", 0, irq);
		wr(apu_pkg::ADDR_LEFT_HI, l[23:8]);
		wr(apu_pkg::ADDR_LEFT_LO, {l[7:0], 8'h00});
		wr(apu_pkg::ADDR_RIGHT_HI, r[23:8]);
		wr(apu_pkg::ADDR_RIGHT_LO, {r[7:0], 8'h00});
		wait_irq();
		n = 0;
		while (dac_strobe !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1 n++;
		end
		check("left", el, dac_left);
		check("right", er, dac_right);
	endtask : play
	// ****************
	// Scenarios
	// ****************
	task automatic t_regs();
		for (int a = 16'hfc34; a <= 16'hfc39; a++) rd(16'(a), 16'h0000);
		rd(apu_pkg::ADDR_VOLUME, 16'h0000);
		rd(apu_pkg::ADDR_MODE, 16'h0000);
		wr(apu_pkg::ADDR_RATE_HI, 16'hffff);
		rd(apu_pkg::ADDR_RATE_HI, 16'h000f);
		wr(apu_pkg::ADDR_RATE_HI, 16'h0000);
		wr(apu_pkg::ADDR_MODE, 16'hffff);
		rd(apu_pkg::ADDR_MODE, 16'h1ff7);
		wr(apu_pkg::ADDR_MODE, 16'h0000);
		wr(apu_pkg::ADDR_LEFT_LO, 16'hffff);
		rd(apu_pkg::ADDR_LEFT_LO, 16'hff00);
		wr(16'hfc3a, 16'hffff);
		rd(16'hfc3a, 16'h0000);
	endtask : t_regs
	task automatic t_rate();
		int c;
		// Increment 0x80000 gives one sample per 256 clocks, 128 in double mode
		wr(apu_pkg::ADDR_RATE_HI, 16'h0008);
		count(2560, c);
		check("normal", 10, c);
		wr(apu_pkg::ADDR_RATE_HI, 16'h0000);
		count(16, c);
		check("idle", 0, c);
		check("clk_en", 0, dac_clk_en);
		wr(apu_pkg::ADDR_MODE, 16'h1800);
		wr(apu_pkg::ADDR_RATE_HI, 16'h0008);
		count(2560, c);
		check("double", 20, c);
		wr(apu_pkg::ADDR_RATE_HI, 16'h0000);
		wr(apu_pkg::ADDR_MODE, 16'h0000);
	endtask : t_rate
	task automatic t_vol();
		wr(apu_pkg::ADDR_IRQ_MASK, 16'h0001);
		// One sample per 512 clocks, longer than a 24-bit serial frame
		wr(apu_pkg::ADDR_RATE_HI, 16'h0004);
		play(16'h0000, 24'h1234ab, 24'hedcb01, 24'h1234ab, 24'hedcb01);
		play(16'h20b0, 24'h100000, 24'hf00000, 24'h11f3c0, 24'he1dc80);
		play(16'hc2c4, 24'h100000, 24'hf00000, 24'h040000, 24'hff0000);
		repeat (470) @(posedge sys_clk);
		#1 check("ser left", 1, got_left);
		check("ser right", 1, got_right);
		wr(apu_pkg::ADDR_IRQ_MASK, 16'h0000);
		#1 check("irq masked", 0, irq);
		wr(apu_pkg::ADDR_RATE_HI, 16'h0000);
	endtask : t_vol
	task automatic print_verdict();
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_regs();
		t_rate();
		t_vol();
		print_verdict();
	end
	// Whole run needs about ten thousand cycles
	initial begin
		#300000;
		fails++;
		print_verdict();
	end
endmodule : apu_playback_tb_top
`default_nettype wire
